// ===== dv/fis_checker.sv
// Concurrent checks on the serializer top pins
`timescale 1ns/1ps
`default_nettype none

module fis_checker (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        temp_warn_trip,
  input wire logic        temp_shutdown_trip,
  input wire logic        overtemp_flag_n,
  input wire logic        serial_out_oe_n,
  input wire logic        overtemp_flag_oe_n,
  input wire logic        load_strobe_n,
  input wire logic        clock_gate_n,
  input wire logic        serial_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  bus_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not stalled");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait");
  idle_ready_a: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest) else $error("wait without request");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved");
  hot_on_a: assert property (temp_warn_trip [*4] |-> !overtemp_flag_n)
    else $error("hot flag not low");
  hot_off_a: assert property (!temp_warn_trip [*4] |-> overtemp_flag_n)
    else $error("hot flag low");
  shdn_float_a: assert property (temp_shutdown_trip [*4]
    |-> serial_out_oe_n && overtemp_flag_oe_n) else $error("still driving");
  shdn_drive_a: assert property (!temp_shutdown_trip [*4]
    |-> !serial_out_oe_n && !overtemp_flag_oe_n) else $error("not driving");
  gate_hold_a: assert property ((load_strobe_n && clock_gate_n) [*6]
    |-> $stable(serial_out)) else $error("shift while gated");

  cover property (avs_read && !avs_waitrequest);
  cover property (!overtemp_flag_n);
  cover property (serial_out_oe_n);
endmodule : fis_checker

bind fis_top fis_checker chk_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .temp_warn_trip(temp_warn_trip),
  .temp_shutdown_trip(temp_shutdown_trip),
  .overtemp_flag_n(overtemp_flag_n), .serial_out_oe_n(serial_out_oe_n),
  .overtemp_flag_oe_n(overtemp_flag_oe_n), .load_strobe_n(load_strobe_n),
  .clock_gate_n(clock_gate_n), .serial_out(serial_out));

`default_nettype wire

// ===== dv/fis_host_model.sv
// Host controller model driving the serializer link pins
`timescale 1ns/1ps
`default_nettype none

module fis_host_model (
  input  wire logic clk_sys,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output var  logic load_strobe_n,
  output var  logic clock_gate_n,
  output var  logic serial_clk,
  output var  logic serial_in
);
  // ****************************************
  // Link master
  // ****************************************
  initial begin
    load_strobe_n = 1'b1;
    clock_gate_n  = 1'b1;
    serial_clk    = 1'b0;
    serial_in     = 1'b0;
  end

  task automatic w4;
    repeat (4) @(posedge clk_sys);
  endtask : w4

  // Eleven frame bits, then one bit that came in on serial_in
  task automatic read_frame(input logic [11:0] s, output logic [11:0] g);
    @(posedge clk_sys);
    load_strobe_n <= 1'b0;
    w4();
    load_strobe_n <= 1'b1;
    w4();
    clock_gate_n <= 1'b0;
    // Link clock of 200 ns: four system cycles low, four high
    for (int i = 0; i < 12; i++) begin
      // Released line reads as the inverse, not the old level
      g[i] = serial_out_oe_n ? ~serial_out : serial_out;
      serial_in <= s[i];
      if (i < 11) begin
        w4();
        serial_clk <= 1'b1;
        w4();
        serial_clk <= 1'b0;
      end
    end
    clock_gate_n <= 1'b1;
  endtask : read_frame
endmodule : fis_host_model

`default_nettype wire

// ===== dv/tb_field_input_serializer.sv
// Self-checking bench for the field input serializer
`timescale 1ns/1ps
`default_nettype none

`include "fis_defs.svh"

module tb_field_input_serializer;
  logic        clk_sys, reset_n, dbl, dbh, uv, tw, ts, rd, wr;
  logic        ld_n, ce_n, sclk, sin, sop, sop_oe_n, hot_n, hot_oe_n;
  logic        wq, irq;
  logic [7:0]  fin;
  logic [3:0]  a;
  logic [31:0] wd, rdd;
  int          bad_count = 0;
  int          compares  = 0;
  int          cyc       = 0;

  fis_top dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .field_input(fin),
    .debounce_select_low(dbl), .debounce_select_high(dbh),
    .load_strobe_n(ld_n), .clock_gate_n(ce_n), .serial_clk(sclk),
    .serial_in(sin), .undervoltage_detect(uv), .temp_warn_trip(tw),
    .temp_shutdown_trip(ts), .serial_out(sop), .serial_out_oe_n(sop_oe_n),
    .overtemp_flag_n(hot_n), .overtemp_flag_oe_n(hot_oe_n),
    .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdd), .avs_waitrequest(wq), .irq(irq));

  fis_host_model host (
    .clk_sys(clk_sys), .serial_out(sop), .serial_out_oe_n(sop_oe_n),
    .load_strobe_n(ld_n), .clock_gate_n(ce_n), .serial_clk(sclk),
    .serial_in(sin));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    a  <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys);
    while (wq !== 1'b0) @(posedge clk_sys);
    q = rdd;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] q;
    chk({sop_oe_n, hot_oe_n, hot_n, irq}, 4'b0010, "reset pins");
    bus(1'b0, `FIS_ADDR_MASK, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "mask reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_frame(input logic [7:0] f, input logic u, w);
    logic [11:0] g, s;
    logic [10:0] e;
    @(posedge clk_sys);
    fin <= f;
    uv  <= u;
    tw  <= w;
    repeat (10) @(posedge clk_sys);
    s = w ? 12'h2aa : 12'h555;
    e = {f, ~w, u, ~^{f, ~w, u}};
    chk(hot_n, !w, "hot pin");
    host.read_frame(s, g);
    chk(g[10:0], e, "frame");
    chk(g[11], s[0], "chain bit");
    $display("frame test done");
  endtask : t_frame

  task automatic t_irq;
    logic [31:0] q;
    bus(1'b1, `FIS_ADDR_STATUS, 32'h0000_000f, q);
    // Undervoltage may already be high from the frame test: toggle it
    @(posedge clk_sys) uv <= ~uv;
    repeat (6) @(posedge clk_sys);
    chk(irq, 1'b0, "irq masked");
    bus(1'b0, `FIS_ADDR_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0002, "status uv");
    bus(1'b1, `FIS_ADDR_MASK, 32'h0000_0002, q);
    @(negedge clk_sys);
    chk(irq, 1'b1, "irq raised");
    bus(1'b1, `FIS_ADDR_STATUS, 32'h0000_0002, q);
    @(negedge clk_sys);
    chk(irq, 1'b0, "irq cleared");
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped");
    $display("irq test done");
  endtask : t_irq

  task automatic t_shdn;
    logic [31:0] q;
    @(posedge clk_sys) ts <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({sop_oe_n, hot_oe_n}, 2'b11, "released");
    bus(1'b0, `FIS_ADDR_STATUS, 32'h0000_0000, q);
    chk(q[3], 1'b1, "shutdown event");
    @(posedge clk_sys) ts <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({sop_oe_n, hot_oe_n}, 2'b00, "driving");
    $display("shutdown test done");
  endtask : t_shdn

  // 1 ms select: old level still held at 39000 cycles, new one by 41500
  task automatic t_deb;
    logic [31:0] q;
    @(posedge clk_sys);
    dbl <= 1'b0;
    dbh <= 1'b1;
    fin <= 8'h3c;
    repeat (39000) @(posedge clk_sys);
    bus(1'b0, `FIS_ADDR_LIVE, 32'h0000_0000, q);
    chk(q[7:0], 8'h96, "held level");
    repeat (2500) @(posedge clk_sys);
    bus(1'b0, `FIS_ADDR_LIVE, 32'h0000_0000, q);
    chk(q[7:0], 8'h3c, "new level");
    $display("debounce test done");
  endtask : t_deb

  // ****************************************
  // Clock, timeout, sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    fin = 8'h00;
    dbl = 1'b1;
    dbh = 1'b0;
    {uv, tw, ts, rd, wr} = 5'h00;
    a  = 4'h0;
    wd = 32'h0000_0000;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_frame(8'h01, 1'b0, 1'b0);
    t_frame(8'h96, 1'b1, 1'b1);
    t_irq();
    t_shdn();
    t_deb();
    end_sim();
  end
endmodule : tb_field_input_serializer

`default_nettype wire

// ===== rtl/fis_debounce.sv
// Synchronisers and debounce filters for the eight field inputs
`timescale 1ns/1ps
`default_nettype none

`include "fis_defs.svh"

module fis_debounce
  import fis_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [7:0]   field_input,
  input  wire fis_db_mode_t mode,
  fis_frame_if.deb          frm
);

  localparam logic [8:0] TICK_LAST  = 9'(`FIS_TICK_CYCLES - 1);
  localparam logic [8:0] SHORT_LAST = 9'(`FIS_DB_SHORT_TICKS - 1);
  localparam logic [8:0] LONG_LAST  = 9'(`FIS_DB_LONG_TICKS - 1);

  fis_tick_t tb;
  fis_tick_t next_tb;
  logic [8:0] limit;

  // ****************************************
  // 10 us time base
  // ****************************************
  always_comb begin
    next_tb      = tb;
    next_tb.tick = 1'b0;
    if (tb.div == TICK_LAST) begin
      next_tb.div  = 9'h000;
      next_tb.tick = 1'b1;
    end else begin
      next_tb.div = tb.div + 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tb <= '0;
    end else begin
      tb <= next_tb;
    end
  end

  // Reserved select code falls back to the longest filter
  assign limit = (mode == FIS_DB_SHORT) ? SHORT_LAST : LONG_LAST;

  // ****************************************
  // Per-channel filter
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `FIS_INPUTS; g++) begin : g_chan
      fis_chan_t ch;
      fis_chan_t next_ch;

      always_comb begin
        next_ch    = ch;
        next_ch.s1 = field_input[g];
        next_ch.s2 = ch.s1;
        if (mode == FIS_DB_BYPASS) begin
          next_ch.stable = ch.s2;
          next_ch.cnt    = 9'h000;
        end else if (ch.s2 == ch.stable) begin
          next_ch.cnt = 9'h000;
        end else if (tb.tick) begin
          if (ch.cnt >= limit) begin
            next_ch.stable = ch.s2;
            next_ch.cnt    = 9'h000;
          end else begin
            next_ch.cnt = ch.cnt + 9'h001;
          end
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          ch <= '0;
        end else begin
          ch <= next_ch;
        end
      end

      assign frm.inputs[g] = ch.stable;
    end
  endgenerate

endmodule : fis_debounce

`default_nettype wire

// ===== rtl/fis_defs.svh
// Constants for the field input serializer: timing, layout, register map
`ifndef FIS_DEFS_SVH
`define FIS_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define FIS_CLK_MHZ        40
`define FIS_TICK_NS        10000
`define FIS_DB_SHORT_NS    1000000
`define FIS_DB_LONG_NS     3000000
`define FIS_TICK_CYCLES    ((`FIS_TICK_NS * `FIS_CLK_MHZ) / 1000)
`define FIS_DB_SHORT_TICKS (`FIS_DB_SHORT_NS / `FIS_TICK_NS)
`define FIS_DB_LONG_TICKS  (`FIS_DB_LONG_NS / `FIS_TICK_NS)

// ****************************************
// Frame layout, output end first
// ****************************************
`define FIS_INPUTS     8
`define FIS_FRAME_BITS 11
`define FIS_POS_PAR    10
`define FIS_POS_UV     9
`define FIS_POS_HOT    8

// ****************************************
// Register map, byte addresses
// ****************************************
`define FIS_ADDR_STATUS 4'h0
`define FIS_ADDR_MASK   4'h4
`define FIS_ADDR_LIVE   4'h8
`define FIS_ADDR_FRAME  4'hc

// ****************************************
// Event bits of status and mask
// ****************************************
`define FIS_EV_INPUT 0
`define FIS_EV_UV    1
`define FIS_EV_OT    2
`define FIS_EV_SHDN  3
`define FIS_EV_W     4

`endif

// ===== rtl/fis_frame_if.sv
// Carrier of debounced inputs and diagnostic bits to the shift register
`timescale 1ns/1ps
`default_nettype none

interface fis_frame_if;
  logic [7:0] inputs;
  logic       uv;
  logic       hot_n;
  logic       par;

  modport deb (output inputs);
  modport top (input inputs, output uv, output hot_n, output par);
  modport shf (input inputs, input uv, input hot_n, input par);
endinterface : fis_frame_if

`default_nettype wire

// ===== rtl/fis_pkg.sv
// Types shared by the field input serializer modules
`default_nettype none

package fis_pkg;

  // Index is {debounce_select_high, debounce_select_low}; open pin reads 1
  typedef enum logic [1:0] {
    FIS_DB_RSVD   = 2'h0,
    FIS_DB_BYPASS = 2'h1,
    FIS_DB_SHORT  = 2'h2,
    FIS_DB_LONG   = 2'h3
  } fis_db_mode_t;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       stable;
    logic [8:0] cnt;
  } fis_chan_t;

  typedef struct packed {
    logic [8:0] div;
    logic       tick;
  } fis_tick_t;

  typedef struct packed {
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_d;
    logic        ld_s1;
    logic        ld_s2;
    logic        ce_s1;
    logic        ce_s2;
    logic        si_s1;
    logic        si_s2;
    logic [10:0] sr;
  } fis_shf_t;

  typedef struct packed {
    logic [1:0]  db_s1;
    logic [1:0]  db_s2;
    logic        uv_s1;
    logic        uv_s2;
    logic        ot_s1;
    logic        ot_s2;
    logic        sd_s1;
    logic        sd_s2;
    logic [7:0]  prev_in;
    logic        prev_uv;
    logic        prev_ot;
    logic        prev_sd;
    logic        hot_n;
    logic        oe_n;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        ack;
    logic [31:0] rdata;
  } fis_top_t;

endpackage : fis_pkg

`default_nettype wire

// ===== rtl/fis_shifter.sv
// Parallel-load, serial-shift frame register on the sampled link pins
`timescale 1ns/1ps
`default_nettype none

`include "fis_defs.svh"

module fis_shifter
  import fis_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic load_strobe_n,
  input  wire logic clock_gate_n,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  fis_frame_if.shf  frm,
  output logic      serial_out,
  output logic [10:0] frame_now
);

  fis_shf_t st;
  fis_shf_t next_st;
  logic     rise;

  assign rise = st.clk_s2 & ~st.clk_d;

  always_comb begin
    next_st        = st;
    next_st.clk_s1 = serial_clk;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_d  = st.clk_s2;
    next_st.ld_s1  = load_strobe_n;
    next_st.ld_s2  = st.ld_s1;
    next_st.ce_s1  = clock_gate_n;
    next_st.ce_s2  = st.ce_s1;
    next_st.si_s1  = serial_in;
    next_st.si_s2  = st.si_s1;
    if (!st.ld_s2) begin
      // Load wins over clock and gate
      next_st.sr = {frm.par, frm.uv, frm.hot_n,
                    frm.inputs[0], frm.inputs[1], frm.inputs[2],
                    frm.inputs[3], frm.inputs[4], frm.inputs[5],
                    frm.inputs[6], frm.inputs[7]};
    end else if (rise && !st.ce_s2) begin
      next_st.sr = {st.sr[9:0], st.si_s2};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // Synced strobe and gate start at idle so reset is not a load
      st       <= '0;
      st.ld_s1 <= 1'b1;
      st.ld_s2 <= 1'b1;
      st.ce_s1 <= 1'b1;
      st.ce_s2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out = st.sr[`FIS_POS_PAR];
  assign frame_now  = st.sr;

endmodule : fis_shifter

`default_nettype wire

// ===== rtl/fis_top.sv
// Field input serializer top: pins, diagnostics, register slave, interrupt
//
// Notes on behaviour
// - Each input accepted only after holding the selected 0, 1 or 3 ms.
// - Host strobes a parallel load, then clocks bits out serially.
// - Serial input feeds the first stage, allowing daisy chains of eight.
// - Odd parity bit covers the shifted status bits.
// - Overtemperature output goes low at the 150 C trip, else high.
// - Load low loads; gate low shifts on rising clock; gate high holds.
// - Frame from output end: parity, undervoltage, overtemp, inputs 0..7.
// - After eleven enabled edges, serial input data reaches the output.
// - Above the 170 C trip, the serial and overtemp outputs go high impedance.
`timescale 1ns/1ps
`default_nettype none

`include "fis_defs.svh"

module fis_top
  import fis_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  field_input,
  input  wire logic        debounce_select_low,
  input  wire logic        debounce_select_high,
  input  wire logic        load_strobe_n,
  input  wire logic        clock_gate_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        undervoltage_detect,
  input  wire logic        temp_warn_trip,
  input  wire logic        temp_shutdown_trip,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  output logic             overtemp_flag_n,
  output logic             overtemp_flag_oe_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  fis_top_t     st;
  fis_top_t     next_st;
  fis_db_mode_t mode;
  logic [3:0]   events;
  logic [10:0]  frame_now;
  logic         bus_req;

  fis_frame_if frm ();

  // ****************************************
  // Filters and shift register
  // ****************************************
  assign mode = fis_db_mode_t'(st.db_s2);

  fis_debounce u_debounce (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .field_input (field_input),
    .mode        (mode),
    .frm         (frm.deb)
  );

  fis_shifter u_shifter (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .load_strobe_n (load_strobe_n),
    .clock_gate_n  (clock_gate_n),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in),
    .frm           (frm.shf),
    .serial_out    (serial_out),
    .frame_now     (frame_now)
  );

  // ****************************************
  // Diagnostic bits into the frame
  // ****************************************
  assign frm.uv    = st.uv_s2;
  assign frm.hot_n = st.hot_n;
  // Total of ones across all eleven bits comes out odd
  assign frm.par   = ~^{st.uv_s2, st.hot_n, frm.inputs};

  // ****************************************
  // Events for the sticky status
  // ****************************************
  always_comb begin
    events                = 4'h0;
    events[`FIS_EV_INPUT] = |(frm.inputs ^ st.prev_in);
    events[`FIS_EV_UV]    = st.uv_s2 ^ st.prev_uv;
    events[`FIS_EV_OT]    = st.ot_s2 ^ st.prev_ot;
    events[`FIS_EV_SHDN]  = st.sd_s2 & ~st.prev_sd;
  end

  assign bus_req = avs_read | avs_write;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st         = st;
    next_st.db_s1   = {debounce_select_high, debounce_select_low};
    next_st.db_s2   = st.db_s1;
    next_st.uv_s1   = undervoltage_detect;
    next_st.uv_s2   = st.uv_s1;
    next_st.ot_s1   = temp_warn_trip;
    next_st.ot_s2   = st.ot_s1;
    next_st.sd_s1   = temp_shutdown_trip;
    next_st.sd_s2   = st.sd_s1;
    next_st.prev_in = frm.inputs;
    next_st.prev_uv = st.uv_s2;
    next_st.prev_ot = st.ot_s2;
    next_st.prev_sd = st.sd_s2;
    next_st.hot_n   = ~st.ot_s2;
    // A shorted driver heats the die, so release rather than fight it
    next_st.oe_n    = st.sd_s2;

    // One wait cycle per request; answer on the second edge
    next_st.ack = bus_req & ~st.ack;

    if (avs_read && !st.ack) begin
      unique case (avs_address)
        `FIS_ADDR_STATUS: next_st.rdata = {28'h000_0000, st.status};
        `FIS_ADDR_MASK:   next_st.rdata = {28'h000_0000, st.mask};
        `FIS_ADDR_LIVE:   next_st.rdata = {19'h0_0000, mode, st.sd_s2,
                                           st.uv_s2, st.ot_s2, frm.inputs};
        `FIS_ADDR_FRAME:  next_st.rdata = {21'h00_0000, frame_now};
        default:          next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Set wins over a clear in the same cycle
    next_st.status = st.status | events;
    if (avs_write && st.ack) begin
      unique case (avs_address)
        `FIS_ADDR_STATUS: begin
          next_st.status = (st.status & ~avs_writedata[3:0]) | events;
        end
        `FIS_ADDR_MASK: begin
          next_st.mask = avs_writedata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st       <= '0;
      st.hot_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign overtemp_flag_n    = st.hot_n;
  assign serial_out_oe_n    = st.oe_n;
  assign overtemp_flag_oe_n = st.oe_n;
  assign avs_readdata       = st.rdata;
  assign avs_waitrequest    = bus_req & ~st.ack;
  assign irq                = |(st.status & st.mask);

endmodule : fis_top

`default_nettype wire
